// *** rtl/token_port_pkg.sv ***
// Constants shared by the host port and serial pin logic
// Overview of operation
// - Link quality input is active low; frames accepted only while it is low.
// - Chip select and write strobe low store host bus into selected register; the code refuses the write while DMA grant is low.
// - Chip select and read strobe low drive selected register; else bus released.
// - Host bus is eight bits, two-way, three-state, shared with DMA.
// - Four register select inputs choose the target, separate from DMA address.
// - Master reset low clears all registers, detach flag set to one; the code leaves the two-entry receive buffer and its words uncleared.
// - Status register zero is initialised on entry to network mode.
// - Receive data sampled on each rising edge of the receive clock.
// - Transmit data changes only on falling edges of the transmit clock.
package token_port_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned SEL_W       = 4;
    localparam int unsigned NUM_REGS    = 16;
    // Register indices on the select inputs
    localparam logic [3:0]  CTRL_IDX    = 4'h0;
    localparam logic [3:0]  STAT0_IDX   = 4'h1;
    localparam logic [3:0]  TX_DATA_IDX = 4'h2;
    localparam logic [3:0]  RX_DATA_IDX = 4'h3;
    // Control register fields
    localparam int unsigned DETACH_BIT  = 0;
    localparam int unsigned NET_MODE_BIT = 1;
    // Reset values
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_RESET  = 8'h01;
    localparam logic [7:0]  STAT0_INIT  = 8'h00;
    // Status 0 fields
    localparam int unsigned RX_AVAIL_BIT = 0;
    localparam int unsigned TX_EMPTY_BIT = 1;
    localparam int unsigned RX_DROP_BIT  = 2;
    localparam int unsigned RX_OVR_BIT   = 3;
endpackage : token_port_pkg

// *** rtl/word_buf_if.sv ***
// Valid/ready carrier between the receive shifter and its two-entry buffer
`timescale 1ns/10ps
interface word_buf_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : word_buf_if

// *** rtl/word_buf2.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module word_buf2 #(
    parameter int unsigned W = 8
) (
    input  wire logic    core_clk,
    input  wire logic    rst,
    word_buf_if.dst      in_port,
    output logic         out_valid,
    input  wire logic    out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0]        cnt;
        logic              rd;
        logic              wr;
    } buf_state_type;

    buf_state_type s_q;
    buf_state_type s_d;

    // Pointer and count update; full stalls the source
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop  = 1'b0;
        s_d  = s_q;
        push = in_port.valid && (s_q.cnt != 2'd2);
        pop  = out_ready && (s_q.cnt != 2'd0);
        if (push) begin
            s_d.mem[s_q.wr] = in_port.data;
            s_d.wr          = ~s_q.wr;
        end
        if (pop) begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_port.ready = (s_q.cnt != 2'd2);
    assign out_valid     = (s_q.cnt != 2'd0);
    assign out_data      = s_q.mem[s_q.rd];
endmodule : word_buf2 // word_buf2

// *** rtl/token_host_port.sv ***
// Host register port, reset handling and serial pin timing of the token controller
`timescale 1ns/10ps
module token_host_port
    import token_port_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              global_init_n,
    input  wire logic              chip_sel_n,
    input  wire logic              host_fetch_pulse_n,
    input  wire logic              host_store_pulse_n,
    input  wire logic [SEL_W-1:0]  host_reg_select,
    input  wire logic [DATA_W-1:0] host_bus_lines_in,
    output logic      [DATA_W-1:0] host_bus_lines_out,
    output logic                   host_bus_lines_oe,
    input  wire logic              dma_grant_n,
    input  wire logic              link_quality_ok_n,
    input  wire logic              serial_in_clk,
    input  wire logic              serial_in_bit,
    input  wire logic              serial_out_clk,
    output logic                   serial_out_bit,
    output logic                   detach_flag,
    output logic                   frame_rejected
);
    // All state of the port in one record
    typedef struct packed {
        logic [2:0]        init_sync;
        logic [2:0]        cs_sync;
        logic [2:0]        rd_sync;
        logic [2:0]        wr_sync;
        logic [2:0]        rclk_sync;
        logic [1:0]        rbit_sync;
        logic [1:0]        qual_sync;
        logic [2:0]        tclk_sync;
        logic [1:0]        grant_sync;
        logic [1:0][SEL_W-1:0]  sel_sync;
        logic [1:0][DATA_W-1:0] din_sync;
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] stat0;
        logic [DATA_W-1:0] tx_hold;
        logic              tx_full;
        logic [DATA_W-1:0] tx_shift;
        logic [3:0]        tx_cnt;
        logic [DATA_W-1:0] rx_shift;
        logic [2:0]        rx_cnt;
        logic              rx_push;
        logic [DATA_W-1:0] rx_word;
        logic              net_prev;
        logic [DATA_W-1:0] bus_out;
        logic              bus_oe;
        logic              txd;
        logic              rejected;
    } port_state_type;

    port_state_type s_q;
    port_state_type s_d;

    word_buf_if #(.W(DATA_W)) rx_if ();
    logic              rx_out_valid;
    logic              rx_out_ready;
    logic [DATA_W-1:0] rx_out_data;

    // Received words wait here; a slow host read loses none until both entries and rx_word are full
    word_buf2 #(.W(DATA_W)) u_rx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_port   (rx_if),
        .out_valid (rx_out_valid),
        .out_ready (rx_out_ready),
        .out_data  (rx_out_data)
    );

    // Word offered until the buffer takes it
    assign rx_if.valid = s_q.rx_push;
    assign rx_if.data  = s_q.rx_word;

    // Synchronised strobes (second stage onward only)
    logic sel_rd;
    logic sel_wr;
    logic rd_fall;
    logic rclk_rise;
    logic tclk_fall;
    logic in_frame;
    logic net_mode;
    // Edge detectors compare the second and third stages
    assign sel_rd    = !s_q.cs_sync[1] && !s_q.rd_sync[1];
    assign sel_wr    = !s_q.cs_sync[1] && !s_q.wr_sync[1];
    assign rd_fall   = sel_rd && s_q.rd_sync[2];
    assign rclk_rise = s_q.rclk_sync[1] && !s_q.rclk_sync[2];
    assign tclk_fall = !s_q.tclk_sync[1] && s_q.tclk_sync[2];
    assign in_frame  = !s_q.qual_sync[1];
    assign net_mode  = s_q.ctrl[NET_MODE_BIT];
    assign rx_out_ready = rd_fall && (s_q.sel_sync[1] == RX_DATA_IDX);

    always_comb begin
        s_d = s_q;
        // Two flip-flops before any pin is read
        s_d.init_sync  = {s_q.init_sync[1:0], global_init_n};
        s_d.cs_sync    = {s_q.cs_sync[1:0], chip_sel_n};
        s_d.rd_sync    = {s_q.rd_sync[1:0], host_fetch_pulse_n};
        s_d.wr_sync    = {s_q.wr_sync[1:0], host_store_pulse_n};
        s_d.rclk_sync  = {s_q.rclk_sync[1:0], serial_in_clk};
        s_d.rbit_sync  = {s_q.rbit_sync[0], serial_in_bit};
        s_d.qual_sync  = {s_q.qual_sync[0], link_quality_ok_n};
        // Select and data ride the same two stages as the strobes
        s_d.sel_sync   = {s_q.sel_sync[0], host_reg_select};
        s_d.din_sync   = {s_q.din_sync[0], host_bus_lines_in};
        s_d.tclk_sync  = {s_q.tclk_sync[1:0], serial_out_clk};
        s_d.grant_sync = {s_q.grant_sync[0], dma_grant_n};
        s_d.rx_push    = s_q.rx_push && !rx_if.ready;
        s_d.net_prev   = net_mode;
        // Write while select and write strobe are low
        // Grant low refuses the write; the host keeps it high while selected
        if (sel_wr && s_q.grant_sync[1]) begin
            unique case (s_q.sel_sync[1])
                CTRL_IDX:    s_d.ctrl = s_q.din_sync[1];
                TX_DATA_IDX: begin
                    s_d.tx_hold = s_q.din_sync[1];
                    s_d.tx_full = 1'b1;
                end
                default:     s_d.ctrl = s_q.ctrl;
            endcase
        end
        // Status 0 set up on entry to network mode
        if (net_mode && !s_q.net_prev) begin
            s_d.stat0 = STAT0_INIT;
        end
        s_d.stat0[RX_AVAIL_BIT] = rx_out_valid;
        s_d.stat0[TX_EMPTY_BIT] = !s_d.tx_full;
        // Drive the bus only during a selected read
        s_d.bus_oe = sel_rd && !sel_wr;
        // Data latched as the read starts, so the pop cannot change it mid-read
        if (rd_fall) begin
            unique case (s_q.sel_sync[1])
                CTRL_IDX:    s_d.bus_out = s_q.ctrl;
                STAT0_IDX:   s_d.bus_out = s_q.stat0;
                RX_DATA_IDX: s_d.bus_out = rx_out_data;
                default:     s_d.bus_out = REG_RESET;
            endcase
        end
        // Reading status clears the sticky drop and overrun flags
        if (rd_fall && s_q.sel_sync[1] == STAT0_IDX) begin
            s_d.stat0[RX_DROP_BIT] = 1'b0;
            s_d.stat0[RX_OVR_BIT]  = 1'b0;
        end
        // Receive: one bit per rising receive clock, gated by quality
        s_d.rejected = 1'b0;
        if (!in_frame) begin
            if (s_q.rx_cnt != 3'd0) begin
                s_d.stat0[RX_DROP_BIT] = 1'b1; // Partial word discarded
                s_d.rejected = 1'b1;
            end
            s_d.rx_cnt = 3'd0;
        end else if (rclk_rise) begin
            s_d.rx_shift = {s_q.rbit_sync[1], s_q.rx_shift[DATA_W-1:1]};
            s_d.rx_cnt   = s_q.rx_cnt + 3'd1;
            if (s_q.rx_cnt == 3'd7) begin
                if (s_q.rx_push && !rx_if.ready) begin
                    s_d.stat0[RX_OVR_BIT] = 1'b1; // Set wins over status read
                end else begin
                    s_d.rx_word = {s_q.rbit_sync[1], s_q.rx_shift[DATA_W-1:1]};
                    s_d.rx_push = 1'b1;
                end
            end
        end
        // Transmit: change output only on falling transmit clock
        if (tclk_fall) begin
            if (s_q.tx_cnt == 4'd0) begin
                if (s_q.tx_full && !s_q.ctrl[DETACH_BIT]) begin
                    s_d.txd      = s_q.tx_hold[0];
                    s_d.tx_shift = {1'b1, s_q.tx_hold[DATA_W-1:1]};
                    s_d.tx_cnt   = 4'd7;
                    s_d.tx_full  = 1'b0;
                end else begin
                    s_d.txd = 1'b1; // Idle marking
                end
            end else begin
                s_d.txd      = s_q.tx_shift[0];
                s_d.tx_shift = {1'b1, s_q.tx_shift[DATA_W-1:1]};
                s_d.tx_cnt   = s_q.tx_cnt - 4'd1;
            end
        end
        // Empty flag follows the holding register after any load
        s_d.stat0[TX_EMPTY_BIT] = !s_d.tx_full;
        // Master reset clears registers, detach set
        if (!s_q.init_sync[1]) begin
            s_d.ctrl     = CTRL_RESET;
            s_d.stat0    = REG_RESET;
            s_d.tx_hold  = REG_RESET;
            s_d.tx_full  = 1'b0;
            s_d.tx_cnt   = 4'd0;
            s_d.rx_cnt   = 3'd0;
            s_d.rx_push  = 1'b0;
            s_d.bus_oe   = 1'b0;
            s_d.txd      = 1'b1;
        end
    end

    // One register stage for the whole state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.ctrl <= CTRL_RESET;
            s_q.txd  <= 1'b1;
            // Pin stages start at idle levels so no false edge follows reset
            s_q.cs_sync    <= 3'b111;
            s_q.rd_sync    <= 3'b111;
            s_q.wr_sync    <= 3'b111;
            s_q.qual_sync  <= 2'b11;
            s_q.tclk_sync  <= 3'b111;
            s_q.grant_sync <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from state flip-flops
    assign host_bus_lines_out = s_q.bus_out;
    assign host_bus_lines_oe  = s_q.bus_oe;
    assign serial_out_bit     = s_q.txd;
    assign detach_flag        = s_q.ctrl[DETACH_BIT];
    assign frame_rejected     = s_q.rejected;
endmodule : token_host_port // token_host_port

// *** bench/token_host_port_sva.sv ***
// Concurrent checks on the token controller host port pins
`timescale 1ns/10ps
module token_host_port_sva
    import token_port_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              global_init_n,
    input wire logic              chip_sel_n,
    input wire logic              host_fetch_pulse_n,
    input wire logic              host_store_pulse_n,
    input wire logic [SEL_W-1:0]  host_reg_select,
    input wire logic [DATA_W-1:0] host_bus_lines_in,
    input wire logic              host_bus_lines_oe,
    input wire logic              dma_grant_n,
    input wire logic              link_quality_ok_n,
    input wire logic              serial_out_clk,
    input wire logic              serial_out_bit,
    input wire logic              detach_flag,
    input wire logic              frame_rejected
);
    logic [3:0] fall_cnt_q;
    // Decoded strobes; grant low refuses the write
    wire rd_sel = !chip_sel_n && !host_fetch_pulse_n;
    wire wr_ctl = !chip_sel_n && !host_store_pulse_n && dma_grant_n && global_init_n
                  && host_reg_select == CTRL_IDX;
    wire wr_bit = host_bus_lines_in[DETACH_BIT];
    // Cycles since the raw transmit clock fell; saturates so it cannot wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) fall_cnt_q <= 4'hf;
        else if ($fell(serial_out_clk)) fall_cnt_q <= 4'h0;
        else if (fall_cnt_q != 4'hf) fall_cnt_q <= fall_cnt_q + 4'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_read_drive: assert property (
        $rose(rd_sel) |-> ##1 !host_bus_lines_oe[*2] ##1 host_bus_lines_oe)
        else $error("bus not driven three cycles after read strobe");
    chk_bus_release: assert property (
        $fell(rd_sel) |-> ##1 host_bus_lines_oe[*2] ##1 !host_bus_lines_oe)
        else $error("bus not released three cycles after read strobe");
    chk_drive_cause: assert property (
        host_bus_lines_oe |-> $past(rd_sel, 3))
        else $error("bus driven without a selected read");
    chk_init_state: assert property (
        (!global_init_n)[*4] |-> ##3 (detach_flag && serial_out_bit && !host_bus_lines_oe))
        else $error("master reset did not initialise outputs");
    chk_ctrl_write: assert property (
        wr_ctl[*4] |-> ##2 (detach_flag == $past(wr_bit, 2)))
        else $error("control write not stored");
    chk_tx_on_fall: assert property (
        $changed(serial_out_bit) |-> fall_cnt_q <= 4'h4)
        else $error("transmit bit changed away from a falling clock edge");
    chk_reject_pulse: assert property (
        frame_rejected |=> !frame_rejected)
        else $error("reject pulse longer than one cycle");
    chk_reject_cause: assert property (
        frame_rejected |-> $past(link_quality_ok_n, 2) || $past(link_quality_ok_n, 3))
        else $error("frame rejected while link quality good");
    cov_read: cover property ($fell(host_bus_lines_oe));
    cov_reject: cover property (frame_rejected);
    cov_attach: cover property ($fell(detach_flag));
endmodule // token_host_port_sva

bind token_host_port token_host_port_sva u_sva (.*);

// *** bench/modem_model.sv ***
// Network modem model: receive clock, data, link quality and transmit clock
`timescale 1ns/10ps
module modem_model (
    output logic       serial_in_clk,
    output logic       serial_in_bit,
    output logic       link_quality_ok_n,
    output logic       serial_out_clk,
    input  wire logic  serial_out_bit
);
    logic [31:0] tx_seen;
    // Clocks stand still between frames
    initial begin
        serial_in_clk = 1'b0;
        serial_in_bit = 1'b1;
        link_quality_ok_n = 1'b1;
        serial_out_clk = 1'b1;
        tx_seen = 32'h0;
    end
    // Sends n bits LSB first; data moves only while the clock is low
    task automatic send(input logic [7:0] b, input int n);
        link_quality_ok_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in_bit = b[i];
            #100 serial_in_clk = 1'b1;
            #100 serial_in_clk = 1'b0;
        end
        serial_in_bit = ~serial_in_bit; // Released line shows no stale bit
        #100 link_quality_ok_n = 1'b1; // mid-word when n is short
    endtask
    // Sample just before each fall, when the bit has long settled
    task automatic tx_run(input int n);
        repeat (n) begin
            #100 tx_seen = {serial_out_bit, tx_seen[31:1]};
            serial_out_clk = 1'b0;
            #100 serial_out_clk = 1'b1;
        end
    endtask
endmodule // modem_model

// *** bench/token_ctrl_host_serial_pins_tb.sv ***
// Self-checking bench for the token controller host port
`timescale 1ns/10ps
module token_ctrl_host_serial_pins_tb;
    import token_port_pkg::*;
    logic core_clk, rst, global_init_n, chip_sel_n, host_fetch_pulse_n, host_store_pulse_n;
    logic dma_grant_n, host_oe, serial_in_bit, serial_in_clk, serial_out_clk;
    logic link_quality_ok_n, host_bus_lines_oe, serial_out_bit, detach_flag, frame_rejected;
    logic [3:0] host_reg_select;
    logic [7:0] host_drv, host_bus_lines_out, v;
    int bad_count, cmp_count, i;
    // Resolved bus; an undriven bus shows the inverse of the last host value
    wire [7:0] host_bus_lines_in = host_bus_lines_oe ? host_bus_lines_out
                                  : host_oe ? host_drv : ~host_drv;
    token_host_port dut (.*);
    modem_model u_modem (.*);
    always #12.5 core_clk = ~core_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes are held five cycles, past the two-stage pin sampling
    task automatic host_wr(input logic [3:0] a, input logic [7:0] d);
        {host_reg_select, host_drv, host_oe} = {a, d, 1'b1};
        {chip_sel_n, host_store_pulse_n} = 2'b00; // read strobe stays high
        cyc(5);
        {chip_sel_n, host_store_pulse_n} = 2'b11;
        cyc(5);
        host_oe = 1'b0;
    endtask
    task automatic host_rd(input logic [3:0] a, output logic [7:0] d);
        host_reg_select = a;
        {chip_sel_n, host_fetch_pulse_n} = 2'b00;
        cyc(5);
        d = host_bus_lines_in;
        {chip_sel_n, host_fetch_pulse_n} = 2'b11;
        cyc(5);
    endtask
    task automatic t_regs;
        chk({7'h0, detach_flag}, 8'h01);
        host_rd(CTRL_IDX, v);
        chk(v, CTRL_RESET);
        host_rd(TX_DATA_IDX, v);
        chk(v, REG_RESET);
        host_wr(CTRL_IDX, 8'h02);
        host_rd(CTRL_IDX, v);
        chk(v, 8'h02);
        chk({7'h0, detach_flag}, 8'h00);
        host_rd(STAT0_IDX, v);
        chk(v & 8'h0d, STAT0_INIT);
        host_wr(4'h6, 8'h03); // grant stays high through every access
        host_wr(4'h5, 8'hff);
        host_rd(CTRL_IDX, v);
        chk(v, 8'h02);
        host_rd(4'h5, v);
        chk(v, REG_RESET);
    endtask
    task automatic t_rx;
        u_modem.send(8'ha5, 8);
        u_modem.send(8'h5a, 8);
        cyc(8);
        host_rd(STAT0_IDX, v);
        chk(v & 8'h01, 8'h01);
        host_rd(RX_DATA_IDX, v);
        chk(v, 8'ha5);
        host_rd(RX_DATA_IDX, v);
        chk(v, 8'h5a);
    endtask
    task automatic t_drop;
        i = 0;
        fork
            u_modem.send(8'hff, 4);
            repeat (80) begin
                cyc(1);
                if (frame_rejected === 1'b1) i++;
            end
        join
        chk(i[7:0], 8'h01);
        host_rd(STAT0_IDX, v);
        chk(v & 8'h05, 8'h04);
        // A second cut word sets drop again; re-entering network mode must clear it
        u_modem.send(8'hff, 4);
        cyc(8);
        host_wr(CTRL_IDX, 8'h00);
        host_wr(CTRL_IDX, 8'h02);
        host_rd(STAT0_IDX, v);
        chk(v & 8'h0d, STAT0_INIT);
    endtask
    task automatic t_tx;
        host_wr(TX_DATA_IDX, 8'h3c);
        u_modem.tx_run(32);
        i = 0;
        while (i < 24 && u_modem.tx_seen[i] === 1'b1) i++;
        chk(u_modem.tx_seen[i+:8], 8'h3c);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence; grant is steady high before master reset lifts
    initial begin
        {core_clk, rst, global_init_n, host_oe, host_drv} = {4'b0100, 8'h00};
        {chip_sel_n, host_fetch_pulse_n, host_store_pulse_n, dma_grant_n} = 4'hf;
        {host_reg_select, bad_count, cmp_count} = 0;
        cyc(20);
        rst = 1'b0;
        cyc(4);
        global_init_n = 1'b1;
        cyc(4);
        t_regs();
        t_rx();
        t_drop();
        t_tx();
        wrap_up();
    end
    // Watchdog well beyond the roughly 18 us the tests need
    initial begin
        #500000;
        bad_count++;
        wrap_up();
    end
endmodule // token_ctrl_host_serial_pins_tb
